// [rtl/uart_status_frame.sv]
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
// Contract
// [RULE1] noise flag sets with receive-available, never on an overrun character
// [RULE2] noise, framing, overrun clear by status read then data access
// [RULE3] framing flag rises for a character with a bad stop bit
// [RULE4] overrun sets on buffer overflow and blocks further transfers
// [RULE5] receive idle is 0 from start detect to stop end, else 1; code sets it again at tick 9 of the stop bit
// [RULE6] moving a character sets receive-available; interrupt if enabled
// [RULE7] error flags set in the same cycle as receive-available
// [RULE8] receive-available clears after status then data read, if buffer empty
// [RULE9] transmit idle when empty and nothing shifting; line high then
// [RULE10] transmit idle clears by status read then data write
// [RULE11] transmit empty sets on shift load, clears by status then write
// [RULE12] enabling transmitter sets transmit empty at once
// [RULE13] function enable off floats both pins; on follows tx/rx enables
// [RULE14] disable discards buffers, resets baud, clears flags, sets idles
// [RULE15] disable aborts transfers but keeps other control settings; code also clears tx_en, rx_en and brk
// [RULE16] length select: 0 gives 8-bit, 1 gives 9-bit with ninth bits
// [RULE17] parity enable generates and checks parity, else no parity bit
// [RULE18] parity type 0 even, 1 odd
// [RULE19] stop select 0 one stop bit, 1 two stop bits
// [RULE20] break finishes buffered data then drives low at least 13 bits
// [RULE21] received ninth bit bit 1 read-only, transmitted ninth bit write-only
// [RULE22] parity error flag only while parity mode selected
// [RULE23] both directions shift least significant bit first at baud rate
// [RULE24] clearing tx or rx enable aborts, resets buffers, floats pin
// [RULE25] baud is clock over 64 or 16 times divisor plus one
// [RULE26] receiver majority-votes three centre samples, noise on disagreement
// [RULE27] start bit accepted only if still low at its mid-point
module uart_status_frame (
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rx_in,
	output logic             tx_out,
	output logic             tx_oe_out,
	output logic             rx_ie_out,
	output logic             rx_irq_out
);
	uart_pkg::ctrl_one_t c1_q;
	uart_pkg::ctrl_two_t c2_q;
	logic [7:0]  div_q;
	logic [7:0]  stat;
	logic        tx_on, rx_on, acc, wr, rd;
	logic        st_rd_q;
	logic        parity_error_flag_q, noise_q, framing_error_flag_q, ovr_q, ravl_q, transmit_idle_flag_q, tempt_q;
	logic [8:0]  thr_q;
	logic        thr_full_q;
	uart_pkg::tx_state_t tst_q;
	uart_pkg::rx_state_t rst_q;
	logic [7:0]  bcnt_q;
	logic [1:0]  pre_q;
	logic        tick;
	logic [3:0]  tos_q, ros_q;
	logic [3:0]  tbit_q, rbit_q;
	logic [11:0] tsh_q;
	logic [3:0]  tlen;
	logic [4:0]  brk_q;
	logic [10:0] rsh_q;
	logic [3:0]  rlen;
	logic [2:0]  smp_q;
	logic        rnoise_q;
	uart_pkg::rx_word_t rxq_q [2];
	logic [1:0]  rxcnt_q;
	logic        push, pop, rclr, rdone_q;
	uart_pkg::rx_word_t rword;

	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
	endfunction : maj3

	function automatic logic par9(input logic [8:0] d, input logic nine,
		input logic odd);
		par9 = ^d[7:0] ^ (nine & d[8]) ^ odd; // [RULE18]
	endfunction : par9

	assign tx_on = c1_q.enable & c2_q.tx_en;
	assign rx_on = c1_q.enable & c2_q.rx_en;
	assign tx_oe_out = tx_on; // [RULE13] [RULE24]
	assign rx_ie_out = rx_on; // [RULE13]
	assign acc = psel_in & penable_in;
	assign wr = acc & pwrite_in;
	assign rd = acc & ~pwrite_in;
	assign pready_out = 1'b1;
	assign pslverr_out = acc && paddr_in > uart_pkg::ADDR_DIVISOR;
	assign stat = {parity_error_flag_q, noise_q, framing_error_flag_q, ovr_q, (rst_q == uart_pkg::RX_IDLE),
		ravl_q, transmit_idle_flag_q, tempt_q}; // [RULE5]
	assign rx_irq_out = ravl_q & c2_q.rx_irq_en; // [RULE6]
	assign pop = rd && paddr_in == uart_pkg::ADDR_DATA && rxcnt_q != 2'd0;
	// ordered clear: data read right after a status read, buffer empty or not
	assign rclr = rd && paddr_in == uart_pkg::ADDR_DATA && st_rd_q; // [RULE2]

	// control registers; disable clears tx and rx enables and break only
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			c1_q  <= uart_pkg::ctrl_one_t'(uart_pkg::CTRL_ONE_RST);
			c2_q  <= uart_pkg::ctrl_two_t'(uart_pkg::CTRL_TWO_RST[3:0]);
			div_q <= uart_pkg::DIVISOR_RST;
		end else begin
			if (wr && paddr_in == uart_pkg::ADDR_CTRL_ONE) begin
				c1_q <= {pwdata_in[7:2], pwdata_in[0]}; // [RULE21]
			end
			if (wr && paddr_in == uart_pkg::ADDR_CTRL_TWO) begin
				c2_q <= {pwdata_in[7:5], pwdata_in[2]};
			end
			if (wr && paddr_in == uart_pkg::ADDR_DIVISOR) begin
				div_q <= pwdata_in[7:0];
			end
			if (!c1_q.enable) begin
				c1_q.brk    <= 1'b0; // [RULE14] [RULE15]
				c2_q.tx_en  <= 1'b0;
				c2_q.rx_en  <= 1'b0;
			end
		end
	end

	// read data
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				uart_pkg::ADDR_STATUS:   prdata_out <= {24'h0, stat};
				uart_pkg::ADDR_CTRL_ONE: prdata_out <= {24'h0, c1_q[6:1],
					rxq_q[0].data[8], 1'b0}; // [RULE21]
				uart_pkg::ADDR_CTRL_TWO: prdata_out <= {24'h0, c2_q[3:1],
					2'b00, c2_q.rx_irq_en, 2'b00};
				uart_pkg::ADDR_DATA:     prdata_out <= {24'h0, rxq_q[0].data[7:0]};
				uart_pkg::ADDR_DIVISOR:  prdata_out <= {24'h0, div_q};
				default:                 prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// status-read arms the ordered clear sequence
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_rd_q <= 1'b0;
		end else if (acc) begin
			st_rd_q <= rd && paddr_in == uart_pkg::ADDR_STATUS;
		end
	end

	// baud generator: tick = clk/(4 or 1)/(div+1), 16 ticks per bit
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bcnt_q <= 8'h00;
			pre_q  <= 2'b00;
		end else if (!c1_q.enable) begin
			bcnt_q <= 8'h00; // [RULE14]
			pre_q  <= 2'b00;
		end else if (bcnt_q == div_q) begin
			bcnt_q <= 8'h00;
			pre_q  <= pre_q + 2'b01;
		end else begin
			bcnt_q <= bcnt_q + 8'h01;
		end
	end
	assign tick = (bcnt_q == div_q) & (c2_q.fast | (pre_q == 2'b11)); // [RULE25]

	// transmit frame length: start + data + parity + stop(s)
	assign tlen = 4'd10 + {3'b0, c1_q.nine_bit} + {3'b0, c1_q.par_en}
		+ {3'b0, c1_q.two_stop}; // [RULE16] [RULE17] [RULE19]

	// transmitter
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tst_q <= uart_pkg::TX_IDLE;
			tsh_q <= 12'hFFF;
			tos_q <= 4'h0;
			tbit_q <= 4'h0;
			brk_q <= 5'd0;
			tx_out <= 1'b1;
		end else if (!tx_on) begin
			tst_q <= uart_pkg::TX_IDLE; // [RULE24] [RULE15]
			tx_out <= 1'b1;
		end else begin
			case (tst_q)
				uart_pkg::TX_IDLE: begin
					tx_out <= 1'b1; // [RULE9]
					tos_q <= 4'h0;
					tbit_q <= 4'h0;
					if (thr_full_q) begin
						tst_q <= uart_pkg::TX_SHIFT;
						// lsb first, parity after data, stop ones [RULE23]
						tsh_q <= c1_q.nine_bit ?
							{1'b1, c1_q.par_en ? par9(thr_q, 1'b1, c1_q.par_odd) : 1'b1,
							 thr_q, 1'b0} :
							{2'b11, c1_q.par_en ? par9(thr_q, 1'b0, c1_q.par_odd) : 1'b1,
							 thr_q[7:0], 1'b0}; // [RULE17] [RULE18]
					end else if (c1_q.brk) begin
						tst_q <= uart_pkg::TX_BREAK; // [RULE20]
						brk_q <= 5'd0;
					end
				end
				uart_pkg::TX_SHIFT: begin
					tx_out <= tsh_q[0];
					if (tick) begin
						tos_q <= tos_q + 4'h1;
						if (tos_q == uart_pkg::OSR_LAST) begin
							tsh_q <= {1'b1, tsh_q[11:1]};
							tbit_q <= tbit_q + 4'h1;
							if (tbit_q == tlen - 4'd1) begin
								tst_q <= uart_pkg::TX_IDLE;
							end
						end
					end
				end
				uart_pkg::TX_BREAK: begin
					tx_out <= 1'b0;
					if (tick) begin
						tos_q <= tos_q + 4'h1;
						if (tos_q == uart_pkg::OSR_LAST &&
							brk_q != uart_pkg::BREAK_BITS) begin
							brk_q <= brk_q + 5'd1;
						end
					end
					if (brk_q == uart_pkg::BREAK_BITS && !c1_q.brk) begin
						tst_q <= uart_pkg::TX_GAP; // [RULE20]
					end
				end
				uart_pkg::TX_GAP: begin
					tx_out <= 1'b1;
					tst_q <= uart_pkg::TX_IDLE;
				end
				default: tst_q <= uart_pkg::TX_IDLE;
			endcase
		end
	end

	// transmit holding register and its flags
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			thr_q <= 9'h000;
			thr_full_q <= 1'b0;
			tempt_q <= 1'b1;
			transmit_idle_flag_q <= 1'b1;
		end else if (!tx_on) begin
			thr_full_q <= 1'b0; // [RULE24] [RULE12] [RULE14]
			tempt_q <= 1'b1;
			transmit_idle_flag_q <= 1'b1;
		end else begin
			if (wr && paddr_in == uart_pkg::ADDR_DATA) begin
				thr_q <= {c1_q.tx_ninth, pwdata_in[7:0]}; // [RULE16]
				thr_full_q <= 1'b1;
			end else if (tst_q == uart_pkg::TX_IDLE && thr_full_q) begin
				thr_full_q <= 1'b0;
			end
			if (tst_q == uart_pkg::TX_IDLE && thr_full_q) begin
				tempt_q <= 1'b1; // [RULE11]
			end else if (wr && paddr_in == uart_pkg::ADDR_DATA && st_rd_q) begin
				tempt_q <= 1'b0; // [RULE11]
			end
			// a data write queues a character, so idle must not re-arm then
			if (tst_q == uart_pkg::TX_IDLE && !thr_full_q && tempt_q
				&& !c1_q.brk
				&& !(wr && paddr_in == uart_pkg::ADDR_DATA)) begin
				transmit_idle_flag_q <= 1'b1; // [RULE9] [RULE10]
			end else if (wr && paddr_in == uart_pkg::ADDR_DATA && st_rd_q) begin
				transmit_idle_flag_q <= 1'b0; // [RULE10]
			end else if (tst_q != uart_pkg::TX_IDLE) begin
				transmit_idle_flag_q <= 1'b0;
			end
		end
	end

	// receive frame length after start: data + parity + one stop
	assign rlen = 4'd9 + {3'b0, c1_q.nine_bit} + {3'b0, c1_q.par_en};

	// receiver
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_q <= uart_pkg::RX_IDLE;
			ros_q <= 4'h0;
			rbit_q <= 4'h0;
			rsh_q <= 11'h000;
			smp_q <= 3'b111;
			rnoise_q <= 1'b0;
			rdone_q <= 1'b0;
		end else if (!rx_on) begin
			rst_q <= uart_pkg::RX_IDLE; // [RULE24] [RULE15]
			rdone_q <= 1'b0;
		end else begin
			rdone_q <= 1'b0;
			case (rst_q)
				uart_pkg::RX_IDLE: begin
					ros_q <= 4'h0;
					rbit_q <= 4'h0;
					rnoise_q <= 1'b0;
					if (!rx_in) begin
						rst_q <= uart_pkg::RX_START; // [RULE5]
					end
				end
				uart_pkg::RX_START: if (tick) begin
					ros_q <= ros_q + 4'h1;
					if (ros_q == uart_pkg::MID_SAMPLE && rx_in) begin
						rst_q <= uart_pkg::RX_IDLE; // [RULE27]
					end else if (ros_q == uart_pkg::OSR_LAST) begin
						rst_q <= uart_pkg::RX_SHIFT;
					end
				end
				uart_pkg::RX_SHIFT: if (tick) begin
					ros_q <= ros_q + 4'h1;
					if (ros_q >= uart_pkg::MID_SAMPLE - 4'h1 &&
						ros_q <= uart_pkg::MID_SAMPLE + 4'h1) begin
						smp_q <= {smp_q[1:0], rx_in}; // [RULE26]
					end
					if (ros_q == uart_pkg::MID_SAMPLE + 4'h2) begin
						// lsb arrives first, shifted in from the top [RULE23]
						rsh_q <= {maj3(smp_q), rsh_q[10:1]};
						if (smp_q != 3'b000 && smp_q != 3'b111) begin
							rnoise_q <= 1'b1; // [RULE26]
						end
						rbit_q <= rbit_q + 4'h1;
						if (rbit_q == rlen - 4'd1) begin
							rst_q <= uart_pkg::RX_IDLE; // [RULE5]
							rdone_q <= 1'b1;
						end
					end
				end
				default: rst_q <= uart_pkg::RX_IDLE;
			endcase
		end
	end

	// align the received frame: stop is the last bit shifted in
	always_comb begin
		rword.noise = rnoise_q;
		rword.framing_error_flag = ~rsh_q[10]; // [RULE3]
		rword.data = 9'h000;
		rword.parity_error_flag = 1'b0;
		case ({c1_q.nine_bit, c1_q.par_en})
			2'b00: rword.data = {1'b0, rsh_q[9:2]};
			2'b01: begin
				rword.data = {1'b0, rsh_q[8:1]};
				rword.parity_error_flag = par9({1'b0, rsh_q[8:1]}, 1'b0, c1_q.par_odd)
					^ rsh_q[9]; // [RULE22]
			end
			2'b10: rword.data = rsh_q[9:1];
			2'b11: begin
				rword.data = rsh_q[8:0];
				rword.parity_error_flag = par9(rsh_q[8:0], 1'b1, c1_q.par_odd)
					^ rsh_q[9]; // [RULE22]
			end
			default: rword.data = 9'h000;
		endcase
	end

	assign push = rdone_q && !ovr_q && rxcnt_q != uart_pkg::RXQ_DEPTH; // [RULE4]

	// two-word receive buffer and receive flags
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rxq_q[0] <= '0;
			rxq_q[1] <= '0;
			rxcnt_q <= 2'd0;
			ravl_q <= 1'b0;
			ovr_q <= 1'b0;
			noise_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
		end else if (!rx_on) begin
			rxcnt_q <= 2'd0; // [RULE14] [RULE24]
			ravl_q <= 1'b0;
			ovr_q <= 1'b0;
			noise_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
		end else begin
			if (pop) begin
				rxq_q[0] <= (push && rxcnt_q == 2'd1) ? rword : rxq_q[1];
				if (push && rxcnt_q == 2'd2) rxq_q[1] <= rword;
			end else if (push) begin
				rxq_q[rxcnt_q[0]] <= rword;
			end
			rxcnt_q <= rxcnt_q + {1'b0, push} - {1'b0, pop};
			if (push) begin
				ravl_q <= 1'b1; // [RULE6]
				noise_q <= noise_q | rword.noise; // [RULE1] [RULE7]
				framing_error_flag_q <= framing_error_flag_q | rword.framing_error_flag; // [RULE3] [RULE7]
				parity_error_flag_q <= parity_error_flag_q | (c1_q.par_en & rword.parity_error_flag); // [RULE7]
			end else if (rclr) begin
				ravl_q <= rxcnt_q > 2'd1; // [RULE8]
				noise_q <= 1'b0; // [RULE2]
				framing_error_flag_q <= 1'b0;
				parity_error_flag_q <= 1'b0;
			end
			if (rdone_q && rxcnt_q == uart_pkg::RXQ_DEPTH && !pop) begin
				ovr_q <= 1'b1; // [RULE4]
			end else if (rclr) begin
				ovr_q <= 1'b0; // [RULE2]
			end
		end
	end

	property p_rx_flags;
		@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(noise_q) |-> ravl_q && !$past(ovr_q);
	endproperty
	a_rx_flags: assert property (p_rx_flags) else $error("noise w/o avail"); // [RULE1]

	property p_ovr_block;
		@(posedge core_clk_in) disable iff (!nrst_in)
		ovr_q && !pop |=> rxcnt_q <= $past(rxcnt_q);
	endproperty
	a_ovr_block: assert property (p_ovr_block) else $error("overrun leak"); // [RULE4]

	property p_transmit_idle_flag_line;
		@(posedge core_clk_in) disable iff (!nrst_in)
		transmit_idle_flag_q && tx_on |-> tx_out;
	endproperty
	a_transmit_idle_flag_line: assert property (p_transmit_idle_flag_line) else $error("idle not high"); // [RULE9]

	property p_float;
		@(posedge core_clk_in) disable iff (!nrst_in)
		!c1_q.enable |-> !tx_oe_out && !rx_ie_out;
	endproperty
	a_float: assert property (p_float) else $error("pins driven"); // [RULE13]

	property p_transmitter_enable_empty;
		@(posedge core_clk_in) disable iff (!nrst_in)
		!tx_on ##1 tx_on |-> tempt_q;
	endproperty
	a_transmitter_enable_empty: assert property (p_transmitter_enable_empty) else $error("empty off"); // [RULE12]

	property p_disable;
		@(posedge core_clk_in) disable iff (!nrst_in)
		!c1_q.enable ##1 !c1_q.enable |-> !ravl_q && !ovr_q && transmit_idle_flag_q
			&& tempt_q && bcnt_q == 8'h00;
	endproperty
	a_disable: assert property (p_disable) else $error("disable state"); // [RULE14]

	property p_ravl_clr;
		@(posedge core_clk_in) disable iff (!nrst_in)
		$fell(ravl_q) && rx_on |-> $past(st_rd_q) && $past(rd)
			&& $past(paddr_in) == uart_pkg::ADDR_DATA;
	endproperty
	a_ravl_clr: assert property (p_ravl_clr) else $error("bad clear"); // [RULE8]

	property p_parity_error_flag_mode;
		@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(parity_error_flag_q) |-> $past(c1_q.par_en);
	endproperty
	a_parity_error_flag_mode: assert property (p_parity_error_flag_mode) else $error("parity off"); // [RULE22]

	property p_break_low;
		@(posedge core_clk_in) disable iff (!nrst_in)
		tst_q == uart_pkg::TX_BREAK && tx_on |=> !tx_out || !tx_on;
	endproperty
	a_break_low: assert property (p_break_low) else $error("break high"); // [RULE20]

	c_rx_word: cover property (@(posedge core_clk_in) $rose(ravl_q));
	c_overrun: cover property (@(posedge core_clk_in) $rose(ovr_q));
	c_break:   cover property (@(posedge core_clk_in)
		tst_q == uart_pkg::TX_BREAK);
	c_tx_done: cover property (@(posedge core_clk_in) $rose(transmit_idle_flag_q));
endmodule : uart_status_frame

// [rtl/uart_pkg.sv]
package uart_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
	localparam logic [7:0] ADDR_DATA     = 8'h0C;
	localparam logic [7:0] ADDR_DIVISOR  = 8'h10;
	// status bit positions
	localparam int ST_PARITY_ERROR_FLAG  = 7;
	localparam int ST_NOISE = 6;
	localparam int ST_FRAMING_ERROR_FLAG  = 5;
	localparam int ST_OVR   = 4;
	localparam int ST_RECEIVE_IDLE_FLAG = 3;
	localparam int ST_RAVL  = 2;
	localparam int ST_TRANSMIT_IDLE_FLAG = 1;
	localparam int ST_TEMPT = 0;
	localparam logic [7:0] STATUS_RST = 8'h0B;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] DIVISOR_RST = 8'h00;
	// baud tick multipliers
	localparam logic [6:0] SLOW_MULT = 7'd64;
	localparam logic [6:0] FAST_MULT = 7'd16;
	// oversampling: one tick is 1/16 bit in fast, 1/16 bit via pre-divide of 4
	localparam logic [3:0] OSR_LAST  = 4'hF;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [4:0] BREAK_BITS = 5'd13;
	localparam logic [1:0] RXQ_DEPTH = 2'd2;

	typedef struct packed {
		logic enable;
		logic nine_bit;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic brk;
		logic tx_ninth;
	} ctrl_one_t;

	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic fast;
		logic rx_irq_en;
	} ctrl_two_t;

	typedef struct packed {
		logic [8:0] data;
		logic       noise;
		logic       framing_error_flag;
		logic       parity_error_flag;
	} rx_word_t;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_SHIFT = 4'b0010,
		TX_BREAK = 4'b0100,
		TX_GAP   = 4'b1000
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_SHIFT = 3'b100
	} rx_state_t;
endpackage : uart_pkg

// [bench/serial_peer.sv]
`timescale 1ns/10ps
module serial_peer (
	input  wire logic clk_in,
	input  wire logic tx_in,
	input  wire logic tx_oe_in,
	output logic      rx_out
);
	logic line;
	// data bit that gets a one-cycle spike at its centre, -1 for none
	int   glitch_at = -1;

	// pull-up holds the line high while the pin floats
	assign line = tx_oe_in ? tx_in : 1'b1;

	initial rx_out = 1'b1;

	task automatic bit_time(input logic v);
		rx_out <= v;
		repeat (16) @(posedge clk_in);
	endtask : bit_time

	// pbad inverts the parity bit on purpose
	task automatic send(input logic [8:0] d, input int nb, input logic pen,
		input logic podd, input logic pbad, input logic stop);
		logic p;
		p = podd ^ pbad;
		@(posedge clk_in);
		bit_time(1'b0);
		for (int i = 0; i < nb; i++) begin
			p = p ^ d[i];
			if (i == glitch_at) begin
				rx_out <= d[i];
				repeat (8) @(posedge clk_in);
				rx_out <= ~d[i];
				@(posedge clk_in);
				rx_out <= d[i];
				repeat (7) @(posedge clk_in);
			end else begin
				bit_time(d[i]);
			end
		end
		if (pen)
			bit_time(p);
		bit_time(stop);
		rx_out <= 1'b1;
	endtask : send

	// samples each bit at its centre; ok reports a high stop bit
	task automatic get(input int nb, input logic pen, output logic [8:0] d,
		output logic p, output logic ok);
		int n;
		d = '0;
		p = 1'b0;
		ok = 1'b0;
		n = 0;
		while (line !== 1'b0 && n < 4000) begin
			@(posedge clk_in);
			n++;
		end
		repeat (8) @(posedge clk_in);
		for (int i = 0; i < nb; i++) begin
			repeat (16) @(posedge clk_in);
			d[i] = line;
		end
		if (pen) begin
			repeat (16) @(posedge clk_in);
			p = line;
		end
		repeat (16) @(posedge clk_in);
		ok = (n < 4000) && (line === 1'b1);
	endtask : get
endmodule : serial_peer

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] A_ST = uart_pkg::ADDR_STATUS;
	localparam logic [7:0] A_C1 = uart_pkg::ADDR_CTRL_ONE;
	localparam logic [7:0] A_C2 = uart_pkg::ADDR_CTRL_TWO;
	localparam logic [7:0] A_DT = uart_pkg::ADDR_DATA;
	localparam logic [7:0] A_DV = uart_pkg::ADDR_DIVISOR;
	logic        core_clk_in;
	logic        nrst_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        rx_in;
	logic        tx_out;
	logic        tx_oe_out;
	logic        rx_ie_out;
	logic        rx_irq_out;
	logic [31:0] rd;
	logic        er;
	int          n_fail;
	int          samples_checked;

	uart_status_frame i_uart_status_frame (.core_clk_in(core_clk_in),
		.nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .rx_in(rx_in), .tx_out(tx_out),
		.tx_oe_out(tx_oe_out), .rx_ie_out(rx_ie_out),
		.rx_irq_out(rx_irq_out));

	serial_peer i_serial_peer (.clk_in(core_clk_in), .tx_in(tx_out),
		.tx_oe_in(tx_oe_out), .rx_out(rx_in));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			wrap_up();
		end
		rd = prdata_out;
		er = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rdr

	task automatic wait_st(input int b);
		int n;
		n = 0;
		do begin
			rdr(A_ST);
			n++;
		end while (rd[b] !== 1'b1 && n < 200);
		if (n >= 200) begin
			n_fail++;
			wrap_up();
		end
	endtask : wait_st

	task automatic t_init;
		rdr(A_ST);
		chk(rd, 32'h0B);
		rdr(A_C1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h14, 32'hFF);
		chk(32'(er), 32'h1);
		rdr(8'h14);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, A_DV, 32'h0);
		// tx and rx enables in control two are held off while the function is off
		apb(1'b1, A_C1, 32'h80);
		apb(1'b1, A_C2, 32'hE4);
		rdr(A_ST);
		chk(32'(rd[1:0]), 32'h3);
		chk(32'({tx_oe_out, rx_ie_out}), 32'h3);
		$display("init done");
	endtask : t_init

	task automatic t_tx;
		logic [7:0] cfg [4];
		logic [7:0] v;
		logic [8:0] d;
		logic       p;
		logic       ok;
		cfg = '{8'h80, 8'hA0, 8'hB8, 8'hC1};
		for (int i = 0; i < 4; i++) begin
			v = 8'h5A + 8'(i);
			apb(1'b1, A_C1, {24'h0, cfg[i]});
			rdr(A_ST);
			fork
				i_serial_peer.get(cfg[i][6] ? 9 : 8, cfg[i][5], d, p, ok);
				begin
					apb(1'b1, A_DT, {24'h0, v});
					rdr(A_ST);
					chk(32'(rd[1:0]), 32'h1);
				end
			join
			chk(32'(ok), 32'h1);
			chk(32'(d), {23'h0, cfg[i][0], v});
			if (cfg[i][5])
				chk(32'(p), 32'(^v ^ cfg[i][4]));
			// a second stop bit keeps the transmitter busy past this read
			repeat (14) @(posedge core_clk_in);
			rdr(A_ST);
			chk(32'(rd[1]), 32'(!cfg[i][3]));
			repeat (26) @(posedge core_clk_in);
			rdr(A_ST);
			chk(32'(rd[1:0]), 32'h3);
			chk(32'(tx_out), 32'h1);
		end
		$display("tx done");
	endtask : t_tx

	task automatic t_rx;
		apb(1'b1, A_C1, 32'h80);
		fork
			i_serial_peer.send(9'h0A5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge core_clk_in);
				rdr(A_ST);
				chk(32'(rd[3]), 32'h0);
			end
		join
		wait_st(uart_pkg::ST_RAVL);
		chk(rd, 32'h0F);
		chk(32'(rx_irq_out), 32'h1);
		rdr(A_DT);
		chk(rd, 32'hA5);
		rdr(A_ST);
		chk(rd, 32'h0B);
		chk(32'(rx_irq_out), 32'h0);
		$display("rx done");
	endtask : t_rx

	task automatic t_err;
		i_serial_peer.send(9'h0B3, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_st(uart_pkg::ST_RAVL);
		chk(32'(rd[5]), 32'h1);
		rdr(A_C1);
		rdr(A_DT);
		rdr(A_ST);
		chk(32'(rd[5]), 32'h1);
		rdr(A_DT);
		rdr(A_ST);
		chk(rd & 32'hF4, 32'h0);
		apb(1'b1, A_C1, 32'hA0);
		i_serial_peer.send(9'h0C3, 8, 1'b1, 1'b0, 1'b1, 1'b1);
		wait_st(uart_pkg::ST_RAVL);
		chk(32'(rd[7]), 32'h1);
		rdr(A_DT);
		i_serial_peer.send(9'h0C3, 8, 1'b1, 1'b0, 1'b0, 1'b1);
		wait_st(uart_pkg::ST_RAVL);
		chk(32'(rd[7]), 32'h0);
		rdr(A_DT);
		chk(rd, 32'hC3);
		i_serial_peer.glitch_at = 2;
		i_serial_peer.send(9'h03C, 8, 1'b1, 1'b0, 1'b0, 1'b1);
		i_serial_peer.glitch_at = -1;
		wait_st(uart_pkg::ST_RAVL);
		chk(32'(rd[7:5]), 32'h2);
		rdr(A_DT);
		chk(rd, 32'h3C);
		$display("errors done");
	endtask : t_err

	task automatic t_ovr;
		apb(1'b1, A_C1, 32'h80);
		for (int i = 0; i < 3; i++)
			i_serial_peer.send(9'(17 * (i + 1)), 8, 1'b0, 1'b0, 1'b0, 1'b1);
		wait_st(uart_pkg::ST_OVR);
		chk(32'(rd[6]), 32'h0);
		rdr(A_DT);
		chk(rd, 32'h11);
		rdr(A_ST);
		chk(32'({rd[4], rd[2]}), 32'h1);
		rdr(A_DT);
		chk(rd, 32'h22);
		rdr(A_ST);
		chk(32'(rd[2]), 32'h0);
		$display("overrun done");
	endtask : t_ovr

	task automatic t_rx9;
		apb(1'b1, A_C1, 32'hC1);
		i_serial_peer.send(9'h1A5, 9, 1'b0, 1'b0, 1'b0, 1'b1);
		wait_st(uart_pkg::ST_RAVL);
		rdr(A_C1);
		chk(32'(rd[1:0]), 32'h2);
		rdr(A_ST);
		rdr(A_DT);
		chk(rd, 32'hA5);
		$display("ninth bit done");
	endtask : t_rx9

	task automatic t_brk;
		int n;
		int lo;
		apb(1'b1, A_C1, 32'h84);
		n = 0;
		while (tx_out !== 1'b0 && n < 500) begin
			@(posedge core_clk_in);
			n++;
		end
		lo = 0;
		repeat (208) begin
			@(posedge core_clk_in);
			if (tx_out === 1'b0)
				lo++;
		end
		chk(32'(lo), 32'hD0);
		apb(1'b1, A_C1, 32'h80);
		$display("break done");
	endtask : t_brk

	task automatic t_dis;
		rdr(A_ST);
		apb(1'b1, A_DT, 32'h55);
		repeat (50) @(posedge core_clk_in);
		apb(1'b1, A_DV, 32'h03);
		apb(1'b1, A_C1, 32'h18);
		rdr(A_ST);
		chk(rd, 32'h0B);
		chk(32'({tx_oe_out, rx_ie_out, tx_out}), 32'h1);
		rdr(A_C2);
		chk(rd, 32'h24);
		rdr(A_C1);
		chk(rd & 32'hFD, 32'h18);
		rdr(A_DV);
		chk(rd, 32'h03);
		$display("disable done");
	endtask : t_dis

	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	initial begin
		nrst_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		n_fail = 0;
		samples_checked = 0;
		repeat (10) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		t_init();
		t_tx();
		t_rx();
		t_err();
		t_ovr();
		t_rx9();
		t_brk();
		t_dis();
		wrap_up();
	end
endmodule : tb_top
